// file: rtl/ncpr_pkg.sv
// package: register map, field layout and reset values of the oscillator preset and calibration bank
package ncpr_pkg;

    // ****************************************************************
    // register addresses
    // ****************************************************************
    localparam logic [11:0] ADDR_OSC_PHASE_CHB_P2 = 12'h254;
    localparam logic [11:0] ADDR_OSC_FREQ_CHB_P3 = 12'h258;
    localparam logic [11:0] ADDR_OSC_PHASE_CHB_P3 = 12'h25C;
    localparam logic [11:0] ADDR_STARTUP_STATE = 12'h270;
    localparam logic [11:0] ADDR_SILICON_REVISION = 12'h297;
    localparam logic [11:0] ADDR_SUPPLY_NOISE_CTL = 12'h2A2;
    localparam logic [11:0] ADDR_SYSREF_AUTOCAL_ENABLE = 12'h2B0;

    // ****************************************************************
    // widths, fields and reset values
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PHASE_W = 16;
    localparam int TAD_W = 17;
    localparam int REV_W = 5;
    localparam int DIG_QUIET_BIT = 5;
    localparam int CLK_QUIET_BIT = 4;
    localparam int AUTOCAL_EN_BIT = 0;
    localparam int INIT_DONE_BIT = 0;
    localparam logic [15:0] PHASE_RESET = 16'h0000;
    localparam logic [31:0] FREQ_RESET = 32'hC0000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] SUPPLY_CTL_RESET = 8'h00;
    localparam logic [7:0] AUTOCAL_RESET = 8'h00;
    // cycles the start-up sequencer waits before reporting completion
    localparam int INIT_CYCLES_DEFAULT = 64;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ncpr_req_s;

    typedef struct packed {
        logic [PHASE_W-1:0] phase_p2;
        logic [PHASE_W-1:0] phase_p3;
        logic [DATA_W-1:0] freq_p3;
        logic chb_active;
    } ncpr_chb_s;

    typedef enum logic [1:0] {
        NCPR_INIT_WAIT = 2'b00,
        NCPR_INIT_DONE = 2'b01
    } ncpr_init_e;

endpackage

// file: rtl/ncpr_init_seq.sv
// file: start-up sequencer that raises the initialization-complete flag
`timescale 1ns/10ps
module ncpr_init_seq
    import ncpr_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYCLES_DEFAULT
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    output logic init_done_o
);

    typedef struct packed {
        ncpr_init_e st;
        logic [15:0] cnt;
    } ncpr_iseq_s;

    ncpr_iseq_s q;
    ncpr_iseq_s next_q;

    always_comb begin
        next_q = q;
        case (q.st)
            NCPR_INIT_WAIT: begin
                if (q.cnt == 16'(INIT_CYCLES - 1)) begin
                    next_q.st = NCPR_INIT_DONE;
                end else begin
                    next_q.cnt = q.cnt + 16'h0001;
                end
            end
            NCPR_INIT_DONE: next_q.st = NCPR_INIT_DONE;
            default: next_q.st = NCPR_INIT_WAIT;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q <= '{st: NCPR_INIT_WAIT, cnt: 16'h0000};
        end else begin
            q <= next_q;
        end
    end

    assign init_done_o = (q.st == NCPR_INIT_DONE);

endmodule

// file: rtl/ncpr_cal_ctl.sv
// file: automatic timing calibration start detection and delay selection
`timescale 1ns/10ps
module ncpr_cal_ctl
    import ncpr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cal_en_i,
    input wire logic cal_complete_i,
    input wire logic [TAD_W-1:0] cal_tad_i,
    input wire logic [TAD_W-1:0] manual_tad_i,
    output logic cal_start_o,
    output logic cal_finished_o,
    output logic [TAD_W-1:0] sample_delay_o
);

    typedef struct packed {
        logic en_prev;
        logic start;
        logic finished;
        logic [TAD_W-1:0] delay;
    } ncpr_cal_s;

    ncpr_cal_s q;
    ncpr_cal_s next_q;

    always_comb begin
        next_q = q;
        next_q.en_prev = cal_en_i;
        next_q.start = cal_en_i && !q.en_prev;
        next_q.finished = cal_en_i && cal_complete_i && !next_q.start;
        if (cal_en_i) begin
            next_q.delay = cal_tad_i;
        end else begin
            next_q.delay = manual_tad_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign cal_start_o = q.start;
    assign cal_finished_o = q.finished;
    assign sample_delay_o = q.delay;

endmodule

// file: rtl/ncpr_regs.sv
// file: register bank for channel-B oscillator presets, start-up status and calibration enable
`timescale 1ns/10ps

// ****************************************************************
// register bank top
// ****************************************************************
module ncpr_regs
    import ncpr_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYCLES_DEFAULT,
    parameter logic [REV_W-1:0] REVISION_DEFAULT = 5'h0A // arbitrary value
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic [DATA_W-1:0] cfg_wdata_i,
    output logic [DATA_W-1:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic interleave_mode_i,
    input wire logic cal_complete_i,
    input wire logic [TAD_W-1:0] cal_tad_i,
    input wire logic [TAD_W-1:0] manual_tad_i,
    output ncpr_chb_s chb_presets_o,
    output logic digital_rail_quieting_o,
    output logic clock_rail_quieting_o,
    output logic cal_start_o,
    output logic cal_finished_o,
    output logic [TAD_W-1:0] sample_delay_o,
    output logic init_done_o
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [PHASE_W-1:0] phase_p2;
        logic [PHASE_W-1:0] phase_p3;
        logic [DATA_W-1:0] freq_p3;
        logic [7:0] revision;
        logic [7:0] supply_ctl;
        logic [7:0] autocal;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } ncpr_regs_s;

    ncpr_regs_s q;
    ncpr_regs_s next_q;
    ncpr_req_s req;
    logic init_done;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    assign req = '{wr: cfg_wr_i, rd: cfg_rd_i, addr: cfg_addr_i, wdata: cfg_wdata_i};

    ncpr_init_seq #(
        .INIT_CYCLES(INIT_CYCLES)
    ) u_init (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .init_done_o(init_done)
    );

    ncpr_cal_ctl u_cal (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .cal_en_i(q.autocal[AUTOCAL_EN_BIT]),
        .cal_complete_i(cal_complete_i),
        .cal_tad_i(cal_tad_i),
        .manual_tad_i(manual_tad_i),
        .cal_start_o(cal_start_o),
        .cal_finished_o(cal_finished_o),
        .sample_delay_o(sample_delay_o)
    );

    // ****************************************************************
    // register writes and read mux
    // ****************************************************************
    always_comb begin
        next_q = q;
        next_q.rvalid = req.rd;
        next_q.rdata = q.rdata;
        if (req.wr) begin
            if (hit(req.addr, ADDR_OSC_PHASE_CHB_P2)) begin
                next_q.phase_p2 = req.wdata[PHASE_W-1:0];
            end
            if (hit(req.addr, ADDR_OSC_PHASE_CHB_P3)) begin
                next_q.phase_p3 = req.wdata[PHASE_W-1:0];
            end
            if (hit(req.addr, ADDR_OSC_FREQ_CHB_P3)) begin
                next_q.freq_p3 = req.wdata;
            end
            if (hit(req.addr, ADDR_SILICON_REVISION)) begin
                next_q.revision = req.wdata[7:0];
            end
            if (hit(req.addr, ADDR_SUPPLY_NOISE_CTL)) begin
                next_q.supply_ctl = req.wdata[7:0];
            end
            if (hit(req.addr, ADDR_SYSREF_AUTOCAL_ENABLE)) begin
                next_q.autocal = req.wdata[7:0];
            end
        end
        if (req.rd) begin
            case (req.addr)
                ADDR_OSC_PHASE_CHB_P2: next_q.rdata = {16'h0000, q.phase_p2};
                ADDR_OSC_PHASE_CHB_P3: next_q.rdata = {16'h0000, q.phase_p3};
                ADDR_OSC_FREQ_CHB_P3: next_q.rdata = q.freq_p3;
                ADDR_STARTUP_STATE: next_q.rdata = {31'h00000000, init_done};
                ADDR_SILICON_REVISION: next_q.rdata = {24'h000000, q.revision};
                ADDR_SUPPLY_NOISE_CTL: next_q.rdata = {24'h000000, q.supply_ctl};
                ADDR_SYSREF_AUTOCAL_ENABLE: next_q.rdata = {24'h000000, q.autocal};
                default: next_q.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q.phase_p2 <= PHASE_RESET;
            q.phase_p3 <= PHASE_RESET;
            q.freq_p3 <= FREQ_RESET;
            q.revision <= {3'h0, REVISION_DEFAULT};
            q.supply_ctl <= SUPPLY_CTL_RESET;
            q.autocal <= AUTOCAL_RESET;
            q.rdata <= 32'h00000000;
            q.rvalid <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cfg_rdata_o = q.rdata;
    assign cfg_rvalid_o = q.rvalid;
    assign init_done_o = init_done;
    assign digital_rail_quieting_o = q.supply_ctl[DIG_QUIET_BIT];
    assign clock_rail_quieting_o = q.supply_ctl[CLK_QUIET_BIT];
    assign chb_presets_o = '{phase_p2: q.phase_p2, phase_p3: q.phase_p3, freq_p3: q.freq_p3,
                             chb_active: !interleave_mode_i};

endmodule

// file: verification/ncpr_regs_sva.sv
// port assertions for the preset and calibration bank
`timescale 1ns/10ps
module ncpr_regs_sva
    import ncpr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cfg_wr_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic [DATA_W-1:0] cfg_wdata_i,
    input wire logic interleave_mode_i,
    input wire logic cal_complete_i,
    input wire logic [TAD_W-1:0] cal_tad_i,
    input wire logic [TAD_W-1:0] manual_tad_i,
    input wire ncpr_chb_s chb_presets_o,
    input wire logic digital_rail_quieting_o,
    input wire logic clock_rail_quieting_o,
    input wire logic cal_start_o,
    input wire logic cal_finished_o,
    input wire logic [TAD_W-1:0] sample_delay_o,
    input wire logic init_done_o
);
    wire wr_q = cfg_wr_i && cfg_addr_i == ADDR_SUPPLY_NOISE_CTL;
    wire wr_c = cfg_wr_i && cfg_addr_i == ADDR_SYSREF_AUTOCAL_ENABLE;
    wire wr_on = wr_c && cfg_wdata_i[AUTOCAL_EN_BIT];
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_dig; wr_q |=> digital_rail_quieting_o == $past(cfg_wdata_i[DIG_QUIET_BIT]); endproperty
    a_dig: assert property (p_dig) else $error("digital quieting mismatch");
    property p_clk; wr_q |=> clock_rail_quieting_o == $past(cfg_wdata_i[CLK_QUIET_BIT]); endproperty
    a_clk: assert property (p_clk) else $error("clock quieting mismatch");
    property p_man; wr_c && !cfg_wdata_i[AUTOCAL_EN_BIT] ##1 1 |=> sample_delay_o == $past(manual_tad_i); endproperty
    a_man: assert property (p_man) else $error("manual delay not used");
    property p_cal; wr_on ##1 1 |=> sample_delay_o == $past(cal_tad_i); endproperty
    a_cal: assert property (p_cal) else $error("calibrated delay not used");
    property p_start; cal_start_o |-> $past(wr_on, 2) ##1 !cal_start_o; endproperty
    a_start: assert property (p_start) else $error("start pulse without enable write");
    property p_fin; cal_finished_o |-> $past(cal_complete_i) && !cal_start_o; endproperty
    a_fin: assert property (p_fin) else $error("finished without completion");
    property p_chb; chb_presets_o.chb_active == !interleave_mode_i; endproperty
    a_chb: assert property (p_chb) else $error("channel b active in interleave");
    property p_init; init_done_o |=> init_done_o; endproperty
    a_init: assert property (p_init) else $error("init flag dropped");
    c_start: cover property (cal_start_o);
    c_fin: cover property (cal_finished_o);
    c_init: cover property ($rose(init_done_o));
endmodule

// file: verification/ncpr_host_model.sv
// host model driving the configuration port
`timescale 1ns/10ps
module ncpr_host_model
    import ncpr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [DATA_W-1:0] cfg_rdata_i,
    input wire logic cfg_rvalid_i,
    output ncpr_req_s req_o
);
    initial req_o = '0;
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge core_clk_i);
        req_o = '{1'b1, 1'b0, a, d};
        @(negedge core_clk_i);
        // released data shows the inverse, not the old value
        req_o = '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge core_clk_i);
        req_o = '{1'b0, 1'b1, a, '1};
        @(negedge core_clk_i);
        req_o = '{1'b0, 1'b0, ~a, '0};
        d = (cfg_rvalid_i === 1'b1) ? cfg_rdata_i : 'x;
    endtask
    task automatic wait_init();
        logic [DATA_W-1:0] d;
        d = '0;
        for (int i = 0; i < 40 && d[INIT_DONE_BIT] !== 1'b1; i++) begin
            rd(ADDR_STARTUP_STATE, d);
        end
    endtask
    task automatic start_cal();
        wr(12'h2B1, 32'h00000005);
        wr(ADDR_SYSREF_AUTOCAL_ENABLE, 32'h00000001);
    endtask
endmodule

// file: verification/ncpr_regs_test.sv
// self-checking bench for the preset and calibration bank
`timescale 1ns/10ps
module ncpr_regs_test
    import ncpr_pkg::*;
;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ncpr_row_s;
    logic core_clk_i, rst_i, mode, done, rvalid, dq, cq, cs, cf, ido;
    logic [TAD_W-1:0] ctad, mtad, sd;
    logic [DATA_W-1:0] rdata, v;
    ncpr_req_s req;
    ncpr_chb_s chb;
    int failures, samples_checked, cycles, starts;
    ncpr_row_s rows[8] = '{'{ADDR_OSC_PHASE_CHB_P2, 32'hFFFF1234, 32'h00001234},
        '{ADDR_OSC_FREQ_CHB_P3, 32'h12345678, 32'h12345678}, '{ADDR_OSC_PHASE_CHB_P3, 32'h0000ABCD, 32'h0000ABCD},
        '{ADDR_SILICON_REVISION, 32'h000000FF, 32'h000000FF}, '{ADDR_SUPPLY_NOISE_CTL, 32'h00000020, 32'h00000020},
        '{ADDR_STARTUP_STATE, 32'h00000000, 32'h00000001}, '{12'h300, 32'h55555555, 32'h00000000},
        '{ADDR_SUPPLY_NOISE_CTL, 32'h00000010, 32'h00000010}};
    ncpr_row_s rsts[6] = '{'{ADDR_OSC_PHASE_CHB_P2, 0, 32'h0}, '{ADDR_OSC_FREQ_CHB_P3, 0, 32'hC0000000},
        '{ADDR_OSC_PHASE_CHB_P3, 0, 32'h0}, '{ADDR_SILICON_REVISION, 0, 32'h0000000A},
        '{ADDR_SUPPLY_NOISE_CTL, 0, 32'h0}, '{ADDR_SYSREF_AUTOCAL_ENABLE, 0, 32'h0}};
    ncpr_host_model h(.core_clk_i(core_clk_i), .cfg_rdata_i(rdata), .cfg_rvalid_i(rvalid), .req_o(req));
    ncpr_regs #(.INIT_CYCLES(4)) DUT(.core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_wr_i(req.wr), .cfg_rd_i(req.rd),
        .cfg_addr_i(req.addr), .cfg_wdata_i(req.wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
        .interleave_mode_i(mode), .cal_complete_i(done), .cal_tad_i(ctad), .manual_tad_i(mtad),
        .chb_presets_o(chb), .digital_rail_quieting_o(dq), .clock_rail_quieting_o(cq), .cal_start_o(cs),
        .cal_finished_o(cf), .sample_delay_o(sd), .init_done_o(ido));
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (2) @(negedge core_clk_i);
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        starts += (cs === 1'b1);
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        {rst_i, mode, done, ctad, mtad} = {1'b1, 1'b0, 1'b0, 17'h05555, 17'h1AAAA};
        repeat (4) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        chk(ido, 0);
        @(negedge core_clk_i);
        chk(sd, mtad);
        h.wait_init();
        chk(ido, 1);
        foreach (rsts[i]) begin
            h.rd(rsts[i].a, v);
            chk(v, rsts[i].e);
        end
        foreach (rows[i]) begin
            h.wr(rows[i].a, rows[i].d);
            h.rd(rows[i].a, v);
            chk(v, rows[i].e);
        end
        chk({dq, cq}, 2'b01);
        chk({chb.phase_p2, chb.phase_p3, chb.freq_p3}, 64'h1234ABCD12345678);
        h.wr(ADDR_SUPPLY_NOISE_CTL, 32'h00000030);
        settle();
        chk({dq, cq}, 2'b11);
        h.wr(ADDR_SYSREF_AUTOCAL_ENABLE, 32'h0);
        chk(sd, mtad);
        h.start_cal();
        settle();
        chk(starts, 1);
        chk(sd, ctad);
        {mtad, done} = {17'h00F0F, 1'b1};
        h.start_cal();
        settle();
        chk({starts, sd, cf}, {32'd1, ctad, 1'b1});
        h.wr(ADDR_SYSREF_AUTOCAL_ENABLE, 32'h0);
        settle();
        chk({sd, cf}, {mtad, 1'b0});
        h.start_cal();
        settle();
        chk(starts, 2);
        mode = 1'b1;
        #1 chk(chb.chb_active, 0);
        wrap_up();
    end
endmodule

bind ncpr_regs ncpr_regs_sva chk_i(.core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .interleave_mode_i(interleave_mode_i),
    .cal_complete_i(cal_complete_i), .cal_tad_i(cal_tad_i), .manual_tad_i(manual_tad_i),
    .chb_presets_o(chb_presets_o), .digital_rail_quieting_o(digital_rail_quieting_o),
    .clock_rail_quieting_o(clock_rail_quieting_o), .cal_start_o(cal_start_o), .cal_finished_o(cal_finished_o),
    .sample_delay_o(sample_delay_o), .init_done_o(init_done_o));
